// ===== hw/scf_pkg.sv
/*
 * Package for the system clock select and flash timing block: register map,
 * field positions, reset values, timing counts and carrier types.
 * Assumes a single 125 MHz clk_sys and an AHB-Lite register bus.
 */
package scf_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SYS_CLK_CFG   = 8'h00; // system_clock_config
    localparam logic [7:0] ADDR_LOOP_CLK_CFG  = 8'h04; // loop_clock_config
    localparam logic [7:0] ADDR_FLASH_CFG     = 8'h08;
    localparam logic [7:0] ADDR_FLASH_CMD     = 8'h0C;
    localparam logic [7:0] ADDR_FLASH_STAT    = 8'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CSS_LSB      = 0;  // clock_source_select [1:0]
    localparam int BYPASS_BIT   = 0;  // oscillator_bypass_bit
    localparam int INTSRC_BIT   = 1;  // prescaler source: 1 = internal clock source
    localparam int PRESCALER_DIVIDER_FIELD_LSB    = 2;  // prescaler_divider_field [11:2]
    localparam int PRESCALER_DIVIDER_FIELD_W      = 10;
    localparam int WS_LSB       = 0;  // flash_wait_state_field [2:0]
    localparam int WS_W         = 3;
    localparam int CMD_PROG_BIT = 0;
    localparam int CMD_ERASE_BIT = 1;
    localparam int CMD_MOD_LSB  = 2;  // module number [3:2]
    localparam int STAT_BUSY_LSB = 0; // [3:0]
    localparam int STAT_DONE_LSB = 4; // [7:4]
    localparam int STAT_CSS_LSB  = 8; // [9:8] active source

    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] CSS_WAKEUP   = 2'h0;
    localparam logic [1:0] CSS_PRESCALE = 2'h2;
    localparam logic [1:0] CSS_DIRECT   = 2'h3;
    localparam logic [1:0] CSS_RESET    = CSS_WAKEUP;
    localparam logic [WS_W-1:0] WS_RESET = 3'h4;
    localparam int FLASH_MODULES = 4;
    localparam int PAGE_BYTES    = 128;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_PROG_NS     = 3500000;  // 3.5 ms page program
    localparam int T_ERASE_NS    = 8000000;  // 8 ms sector/page erase
    localparam int PROG_CYC      = T_PROG_NS / CLK_PERIOD_NS;   // longest: round down
    localparam int ERASE_CYC     = T_ERASE_NS / CLK_PERIOD_NS;
    localparam int TMR_W         = 20;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ext_in;    // external_clock_input_pin level
        logic crystal;   // crystal_input_pin / oscillator level
        logic internal;  // internal clock source level
        logic pll;       // loop output level
        logic wakeup;    // wakeup clock level
    } scf_clk_src_t;

    typedef struct packed {
        logic valid;     // one-cycle access start
        logic seq;       // sequential access
    } scf_flash_req_t;

    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_WAIT = 1'b1
    } scf_acc_state_t;

endpackage : scf_pkg

// ===== hw/scf_top.sv
/*
 * System clock source select with K1 prescaler, flash wait-state sequencing
 * and flash program/erase timers, all behind an AHB-Lite slave.
 * Assumes clock source levels arrive synchronous to clk_sys; the system
 * clock is delivered as a one-cycle enable pulse sys_clk_en.
 */
// Overview of operation
// - select 11 runs system clock straight from external input, same rate.
// - select 10 with bypass 1 divides oscillator clock by factor K1.
// - prescaler source is crystal oscillator or internal clock, by config bit.
// - K1 equals divider field plus one; factor 1 passes source through.
// - largest factor divides source by 1024.
// - wait states apply only to non-sequential flash accesses.
// - page program covers 128 bytes, finishes within 3.5 ms.
// - sector or page erase finishes within 8 ms.
// - select 10 with bypass 0 takes system clock from loop output.
// - select 00 runs system clock from wakeup clock source.
module scf_top #(
    parameter int PROG_CYCLES  = scf_pkg::PROG_CYC,
    parameter int ERASE_CYCLES = scf_pkg::ERASE_CYC
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // clock sources and system clock enable
    input  wire scf_pkg::scf_clk_src_t clk_src,
    output logic                       sys_clk_en,
    // flash access port
    input  wire scf_pkg::scf_flash_req_t flash_req,
    output logic                       flash_ack,
    // flash program/erase state
    output logic [3:0]                 flash_busy
);
    import scf_pkg::*;

    // ----------------------------------------------------------------
    // registers and bus phase
    // ----------------------------------------------------------------
    logic [1:0]         css,       next_css;
    logic               bypass,    next_bypass;
    logic               intsrc,    next_intsrc;
    logic [PRESCALER_DIVIDER_FIELD_W-1:0] prescaler_divider_field,     next_prescaler_divider_field;
    logic [WS_W-1:0]    ws,        next_ws;
    logic [3:0]         done,      next_done;
    logic               dp_wr,     next_dp_wr;
    logic [7:0]         dp_addr,   next_dp_addr;
    logic [31:0]        rdata_q,   next_rdata;
    logic [3:0]         start_prog;
    logic [3:0]         start_erase;
    logic [3:0]         tmr_fin;
    logic               addr_ok;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign addr_ok   = hsel & htrans[1] & hready;

    always_comb begin
        next_css     = css;
        next_bypass  = bypass;
        next_intsrc  = intsrc;
        next_prescaler_divider_field   = prescaler_divider_field;
        next_ws      = ws;
        next_done    = done;
        next_dp_wr   = addr_ok & hwrite;
        next_dp_addr = addr_ok ? haddr[7:0] : dp_addr;
        next_rdata   = rdata_q;
        start_prog   = 4'h0;
        start_erase  = 4'h0;
        if (dp_wr) begin
            unique case (dp_addr)
                ADDR_SYS_CLK_CFG:  next_css = hwdata[CSS_LSB +: 2];
                ADDR_LOOP_CLK_CFG: begin
                    next_bypass = hwdata[BYPASS_BIT];
                    next_intsrc = hwdata[INTSRC_BIT];
                    next_prescaler_divider_field  = hwdata[PRESCALER_DIVIDER_FIELD_LSB +: PRESCALER_DIVIDER_FIELD_W];
                end
                ADDR_FLASH_CFG:    next_ws = hwdata[WS_LSB +: WS_W];
                ADDR_FLASH_CMD: begin
                    // a command to a busy module is ignored
                    start_prog[hwdata[CMD_MOD_LSB +: 2]]  = hwdata[CMD_PROG_BIT];
                    start_erase[hwdata[CMD_MOD_LSB +: 2]] = hwdata[CMD_ERASE_BIT]
                                                         & ~hwdata[CMD_PROG_BIT];
                    start_prog  = start_prog & ~flash_busy;
                    start_erase = start_erase & ~flash_busy;
                end
                ADDR_FLASH_STAT:   next_done = done & ~hwdata[STAT_DONE_LSB +: 4];
                default: ;
            endcase
        end
        // completion beats a same-cycle write-one clear
        next_done = next_done | tmr_fin;
        if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_SYS_CLK_CFG:  next_rdata = {30'h0, css};
                ADDR_LOOP_CLK_CFG: next_rdata = {20'h0, prescaler_divider_field, intsrc, bypass};
                ADDR_FLASH_CFG:    next_rdata = {29'h0, ws};
                ADDR_FLASH_STAT:   next_rdata = {22'h0, css, done, flash_busy};
                default:           next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            css     <= CSS_RESET;
            bypass  <= 1'b0;
            intsrc  <= 1'b0;
            prescaler_divider_field   <= '0;
            ws      <= WS_RESET;
            done    <= 4'h0;
            dp_wr   <= 1'b0;
            dp_addr <= 8'h00;
            rdata_q <= 32'h0;
        end else begin
            css     <= next_css;
            bypass  <= next_bypass;
            intsrc  <= next_intsrc;
            prescaler_divider_field   <= next_prescaler_divider_field;
            ws      <= next_ws;
            done    <= next_done;
            dp_wr   <= next_dp_wr;
            dp_addr <= next_dp_addr;
            rdata_q <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // clock source select and K1 prescaler
    // ----------------------------------------------------------------
    scf_clk_src_t       src_q;
    logic [PRESCALER_DIVIDER_FIELD_W-1:0] pre_cnt, next_pre_cnt;
    logic               sys_en_q, next_sys_en;
    logic               ext_edge, osc_edge, pll_edge, wu_edge, osc_lvl;

    // sources are synchronous levels, so rising edges are taken directly
    assign osc_lvl  = intsrc ? clk_src.internal : clk_src.crystal;
    assign ext_edge = clk_src.ext_in & ~src_q.ext_in;
    assign osc_edge = osc_lvl & ~(intsrc ? src_q.internal : src_q.crystal);
    assign pll_edge = clk_src.pll & ~src_q.pll;
    assign wu_edge  = clk_src.wakeup & ~src_q.wakeup;
    assign sys_clk_en = sys_en_q;

    always_comb begin
        next_pre_cnt = pre_cnt;
        next_sys_en  = 1'b0;
        unique case (css)
            CSS_DIRECT:   next_sys_en = ext_edge;
            CSS_PRESCALE: begin
                if (bypass) begin
                    // K1 = field + 1, so 1023 gives the divide-by-1024 floor
                    if (osc_edge) begin
                        if (pre_cnt >= prescaler_divider_field) begin
                            next_pre_cnt = '0;
                            next_sys_en  = 1'b1;
                        end else begin
                            next_pre_cnt = pre_cnt + 1'b1;
                        end
                    end
                end else begin
                    next_sys_en = pll_edge;
                end
            end
            CSS_WAKEUP:   next_sys_en = wu_edge;
            default:      next_sys_en = 1'b0;
        endcase
        // restart the divide when not prescaling so a new K1 starts clean
        if (!(css == CSS_PRESCALE && bypass)) next_pre_cnt = '0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_q    <= '0;
            pre_cnt  <= '0;
            sys_en_q <= 1'b0;
        end else begin
            src_q    <= clk_src;
            pre_cnt  <= next_pre_cnt;
            sys_en_q <= next_sys_en;
        end
    end

    // ----------------------------------------------------------------
    // flash access wait states
    // ----------------------------------------------------------------
    scf_acc_state_t  acc_st, next_acc_st;
    logic [WS_W-1:0] ws_cnt, next_ws_cnt;
    logic            ack_q,  next_ack;

    assign flash_ack = ack_q;

    always_comb begin
        next_acc_st = acc_st;
        next_ws_cnt = ws_cnt;
        next_ack    = 1'b0;
        unique case (acc_st)
            ACC_IDLE: begin
                if (flash_req.valid) begin
                    // sequential hits come from prefetch and skip wait states
                    if (flash_req.seq || ws == '0) begin
                        next_ack = 1'b1;
                    end else begin
                        next_ws_cnt = ws;
                        next_acc_st = ACC_WAIT;
                    end
                end
            end
            ACC_WAIT: begin
                // wait states are counted in system clock periods
                if (sys_en_q) begin
                    next_ws_cnt = ws_cnt - 1'b1;
                    if (ws_cnt == 3'h1) begin
                        next_ack    = 1'b1;
                        next_acc_st = ACC_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_st <= ACC_IDLE;
            ws_cnt <= '0;
            ack_q  <= 1'b0;
        end else begin
            acc_st <= next_acc_st;
            ws_cnt <= next_ws_cnt;
            ack_q  <= next_ack;
        end
    end

    // ----------------------------------------------------------------
    // per-module program/erase timers
    // ----------------------------------------------------------------
    localparam logic [TMR_W-1:0] PROG_LEN  = TMR_W'(PROG_CYCLES);
    localparam logic [TMR_W-1:0] ERASE_LEN = TMR_W'(ERASE_CYCLES);

    generate
        for (genvar m = 0; m < FLASH_MODULES; m++) begin : g_mod
            logic [TMR_W-1:0] tmr, next_tmr;
            always_comb begin
                next_tmr   = tmr;
                tmr_fin[m] = 1'b0;
                if (start_prog[m]) begin
                    next_tmr = PROG_LEN;
                end else if (start_erase[m]) begin
                    next_tmr = ERASE_LEN;
                end else if (tmr != '0) begin
                    next_tmr   = tmr - 1'b1;
                    tmr_fin[m] = (tmr == TMR_W'(1));
                end
            end
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    tmr <= '0;
                end else begin
                    tmr <= next_tmr;
                end
            end
            assign flash_busy[m] = (tmr != '0);
        end
    endgenerate

endmodule : scf_top

// ===== tb/scf_chk.sv
/*
 * Port checker for scf_top: clock tick, flash access and busy timing.
 * Assumes word writes on AHB-Lite; bound to every scf_top instance below.
 */
module scf_chk
    import scf_pkg::*;
#(
    parameter int PROG_CYCLES  = 20,
    parameter int ERASE_CYCLES = 40
) (
    // clock and reset
    input wire logic           clk_sys,
    input wire logic           rst_n,
    // ahb-lite
    input wire logic           hsel,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic [2:0]     hsize,
    input wire logic [31:0]    hwdata,
    input wire logic           hready,
    input wire logic [31:0]    hrdata,
    input wire logic           hreadyout,
    input wire logic           hresp,
    // sources and flash
    input wire scf_clk_src_t   clk_src,
    input wire logic           sys_clk_en,
    input wire scf_flash_req_t flash_req,
    input wire logic           flash_ack,
    input wire logic [3:0]     flash_busy
);
    timeunit 1ns;
    timeprecision 100ps;
    import scf_pkg::*;
    // ----------------------------------------
    // config mirror, decoded from bus writes
    // ----------------------------------------
    logic [1:0]  css, css_o, next_css;
    logic        byp, next_byp, wp, next_wp;
    logic [2:0]  ws, next_ws;
    logic [7:0]  wa, next_wa;
    logic [19:0] bc, next_bc;
    always_comb begin
        next_wp = hsel & htrans[1] & hready & hwrite;
        next_wa = haddr[7:0];
        next_css = css;
        next_byp = byp;
        next_ws = ws;
        if (wp && wa == ADDR_SYS_CLK_CFG) next_css = hwdata[1:0];
        if (wp && wa == ADDR_LOOP_CLK_CFG) next_byp = hwdata[BYPASS_BIT];
        if (wp && wa == ADDR_FLASH_CFG) next_ws = hwdata[2:0];
        next_bc = flash_busy[0] ? bc + 20'h1 : 20'h0;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {css, css_o, byp, wp, wa, bc} <= '0;
            ws <= WS_RESET;
        end else begin
            {css, css_o, byp, wp, wa, bc} <= {next_css, css, next_byp, next_wp, next_wa, next_bc};
            ws <= next_ws;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ready_high_a: assert property (hreadyout) else $error("hreadyout low");
    okay_resp_a: assert property (!hresp) else $error("hresp not okay");
    direct_tick_a: assert property (css == CSS_DIRECT && css_o == css &&
        $rose(clk_src.ext_in) |=> sys_clk_en) else $error("direct tick missing");
    wake_tick_a: assert property (css == CSS_WAKEUP && css_o == css &&
        $rose(clk_src.wakeup) |=> sys_clk_en) else $error("wakeup tick missing");
    loop_tick_a: assert property (css == CSS_PRESCALE && css_o == css && !byp &&
        $rose(clk_src.pll) |=> sys_clk_en) else $error("loop tick missing");
    seq_ack_a: assert property (flash_req.valid && flash_req.seq |=> flash_ack)
        else $error("sequential ack late");
    nonseq_wait_a: assert property (flash_req.valid && !flash_req.seq && ws != 3'h0
        |=> !flash_ack) else $error("wait states skipped");
    busy_len_a: assert property ($fell(flash_busy[0]) |->
        bc == PROG_CYCLES || bc == ERASE_CYCLES) else $error("busy length wrong");
endmodule : scf_chk

bind scf_top scf_chk #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) scf_chk_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .clk_src(clk_src), .sys_clk_en(sys_clk_en),
    .flash_req(flash_req), .flash_ack(flash_ack), .flash_busy(flash_busy));

// ===== tb/tb_sysclk_select_flash_timing.sv
/*
 * Self-checking bench for scf_top with a cycle model of the clock tick.
 * Assumes the checker is bound by its own file; random source levels.
 */
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_sysclk_select_flash_timing;
    timeunit 1ns;
    timeprecision 100ps;
    import scf_pkg::*;
    logic           clk_sys = 1'b0;
    logic           rst_n = 1'b0;
    logic           hsel = 1'b0;
    logic           hwrite = 1'b0;
    logic [1:0]     htrans = 2'h0;
    logic [31:0]    haddr = 32'h0;
    logic [31:0]    hwdata = 32'h0;
    logic [31:0]    hrdata, seed = 32'h0A5B53CD;
    logic           hreadyout, hresp, sys_clk_en, flash_ack, src_en = 1'b0, chk_en = 1'b0;
    wire logic      hready = hreadyout;
    logic [3:0]     flash_busy;
    scf_clk_src_t   clk_src = '0;
    scf_flash_req_t flash_req = '0;
    int             bad_count = 0, comparisons = 0, m_css, m_byp, m_int, m_k1, m_cnt;
    logic [4:0]     m_prev = '0;
    logic           m_exp = 1'b0;
    always #4 clk_sys = ~clk_sys;
    scf_top #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) scf_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .clk_src(clk_src), .sys_clk_en(sys_clk_en),
        .flash_req(flash_req), .flash_ack(flash_ack), .flash_busy(flash_busy));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // --------------------------------------------
    // random sources and tick model
    // --------------------------------------------
    always @(posedge clk_sys) begin
        logic [4:0] r;
        seed = xs(seed);
        clk_src <= src_en ? seed[4:0] : 5'h0;
        if (chk_en) `CHK("sys_clk_en", m_exp, sys_clk_en)
        r = clk_src & ~m_prev;
        m_prev = clk_src;
        m_exp = (m_css == 3) ? r[4] : (m_css == 0) ? r[0] : (m_css == 2 && m_byp == 0) & r[1];
        if (m_css != 2) m_cnt = 0;
        if (m_css == 2 && m_byp == 1 && r[m_int ? 2 : 3]) begin
            m_cnt++;
            m_exp = (m_cnt == m_k1);
            if (m_exp) m_cnt = 0;
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin bad_count++; stop_test(); end
    endtask : wait_rdy
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb
    // sources held low while switching so both counters restart together
    task automatic cfg(input int css, byp, isrc, prescaler_divider_field);
        logic [31:0] d;
        chk_en <= 1'b0;
        src_en <= 1'b0;
        ahb(1'b1, ADDR_SYS_CLK_CFG, 32'h1, d);
        ahb(1'b1, ADDR_LOOP_CLK_CFG, 32'(prescaler_divider_field << 2 | isrc << 1 | byp), d);
        ahb(1'b1, ADDR_SYS_CLK_CFG, 32'(css), d);
        ahb(1'b0, ADDR_FLASH_STAT, 32'h0, d);
        `CHK("active select", 2'(css), d[9:8])
        m_css <= css;
        m_byp <= byp;
        m_int <= isrc;
        m_k1  <= prescaler_divider_field + 1;
        m_cnt <= 0;
        chk_en <= 1'b1;
        src_en <= 1'b1;
    endtask : cfg
    task automatic fetch(input logic sq, input int ws);
        int np;
        logic lp;
        np = 0;
        lp = 1'b0;
        @(posedge clk_sys);
        flash_req <= '{valid: 1'b1, seq: sq};
        @(posedge clk_sys);
        flash_req <= '0;
        repeat (3000) begin
            @(posedge clk_sys);
            if (flash_ack === 1'b1) break;
            lp = sys_clk_en;
            np += int'(sys_clk_en);
        end
        `CHK("flash_ack", 1'b1, flash_ack)
        `CHK("wait ticks", sq ? 0 : ws, np)
        `CHK("ack after tick", !sq, lp)
    endtask : fetch
    // --------------------------------------------
    // main sequence
    // --------------------------------------------
    initial begin
        logic [31:0] d;
        int tc[8][5] = '{'{3, 0, 0, 0, 200}, '{0, 0, 0, 0, 200}, '{2, 0, 0, 0, 200},
            '{2, 1, 0, 0, 200}, '{2, 1, 1, 2, 300}, '{2, 1, 0, 1, 200}, '{1, 0, 0, 0, 100},
            '{2, 1, 1, 1023, 9000}};
        logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
        logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h4, 32'h0, 32'h0};
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b1, 8'h20, 32'hFFFFFFFF, d);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, ra[i], 32'h0, d);
            `CHK("reset value", rv[i], d)
        end
        $display("test registers done");
        foreach (tc[i]) begin
            cfg(tc[i][0], tc[i][1], tc[i][2], tc[i][3]);
            repeat (tc[i][4]) @(posedge clk_sys);
        end
        $display("test clock select done");
        cfg(3, 0, 0, 0);
        for (int w = 1; w < 5; w++) begin
            ahb(1'b1, ADDR_FLASH_CFG, 32'(w), d);
            fetch(1'b0, w);
            fetch(1'b1, w);
        end
        $display("test flash access done");
        ahb(1'b1, ADDR_FLASH_CMD, 32'h1, d);
        ahb(1'b1, ADDR_FLASH_CMD, 32'hE, d);
        ahb(1'b1, ADDR_FLASH_CMD, 32'h1, d);
        `CHK("busy", 4'h9, flash_busy)
        repeat (60) @(posedge clk_sys);
        ahb(1'b0, ADDR_FLASH_STAT, 32'h0, d);
        `CHK("done", 8'h90, d[7:0])
        ahb(1'b1, ADDR_FLASH_STAT, 32'h90, d);
        ahb(1'b1, ADDR_FLASH_CMD, 32'h2, d);
        ahb(1'b0, ADDR_FLASH_STAT, 32'h0, d);
        `CHK("erase running", 8'h01, d[7:0])
        repeat (60) @(posedge clk_sys);
        $display("test program erase done");
        // reset returns the select to wakeup, which the tick model does not follow
        chk_en <= 1'b0;
        src_en <= 1'b0;
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        ahb(1'b0, ADDR_FLASH_CFG, 32'h0, d);
        `CHK("wait reset", 32'h4, d)
        $display("test second reset done");
        stop_test();
    end
endmodule : tb_sysclk_select_flash_timing
